// file: logic/lnmi_regs.svh
// constants of the legacy nmi / speaker / power management port block
// assumes byte-wide i/o cycles already decoded to a 16-bit i/o address
`ifndef LNMI_REGS_SVH
`define LNMI_REGS_SVH

// ----------------------------------------------------------------
// i/o addresses
// ----------------------------------------------------------------
`define LNMI_NSC_ADDR    16'h0061
`define LNMI_MASK_ADDR   16'h0070
`define LNMI_PMCMD_ADDR  16'h00B2
`define LNMI_PMSTAT_ADDR 16'h00B3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LNMI_B_SERR_ST   7
`define LNMI_B_CHK_ST    6
`define LNMI_B_CNT2      5
`define LNMI_B_REFR      4
`define LNMI_B_CHK_DIS   3
`define LNMI_B_SERR_DIS  2
`define LNMI_B_SPK_EN    1
`define LNMI_B_GATE      0
`define LNMI_B_MASK      7
`define LNMI_B_SMI_ENABLE_REG_PM  7
`define LNMI_B_CTL_SMI   0
`define LNMI_B_CTL_STP   1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LNMI_CTRL_RST    4'h0
`define LNMI_MASK_RST    1'h1
`define LNMI_RTC_RST     7'h00
`define LNMI_PM_RST      8'h00

`endif

// file: logic/lnmi_pkg.sv
// types of the legacy nmi / speaker / power management port block
// assumes lnmi_regs.svh is included by the files using the constants
package lnmi_pkg;
  typedef logic [7:0] lnmi_byte_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
  } lnmi_sync_st_t;

  typedef struct packed {
    logic serr_st;
    logic chk_st;
  } lnmi_src_st_t;

  typedef struct packed {
    logic [3:0] ctrl;
    logic       refr;
    logic       mask;
    logic [6:0] rtc;
    lnmi_byte_t pm_cmd;
    lnmi_byte_t pm_stat;
    lnmi_byte_t rdata;
    logic       claim;
    logic       fwd;
    logic       fwd_wr;
    lnmi_byte_t fwd_data;
    logic       nmi;
    logic       spk;
    logic       gate;
    logic       smi;
    logic       stp_n;
  } lnmi_top_st_t;
endpackage

// file: logic/lnmi_src_if.sv
// nmi source signals between the port logic and the source latches
// assumes one clock domain, core_clk
`timescale 1ns/1ps
interface lnmi_src_if;
  logic serr_evt;
  logic chk_lvl;
  logic serr_dis;
  logic chk_dis;
  logic serr_st;
  logic chk_st;

  modport latch (input serr_evt, input chk_lvl, input serr_dis, input chk_dis,
                 output serr_st, output chk_st);
  modport ctl   (output serr_evt, output chk_lvl, output serr_dis, output chk_dis,
                 input serr_st, input chk_st);
endinterface

// file: logic/lnmi_sync.sv
// two-stage synchroniser for the two nmi source pins, with edge history
// assumes active-low pins from outside the core_clk domain
`timescale 1ns/1ps
module lnmi_sync (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [1:0] pin_n,
  output logic      [1:0] low_lvl,
  output logic      [1:0] fall
);
  import lnmi_pkg::*;

  lnmi_sync_st_t st_r;
  lnmi_sync_st_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_n;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3};
    end else begin
      st_r <= st_nxt;
    end
  end

  // only the second stage and later are looked at
  for (genvar i = 0; i < 2; i++) begin : g_bit
    assign low_lvl[i] = ~st_r.s2[i];
    assign fall[i]    = st_r.s3[i] & ~st_r.s2[i];
  end
endmodule // lnmi_sync

// file: logic/lnmi_src.sv
// latched nmi source status for the system error and channel check sources
// assumes synchronised event inputs on core_clk
`timescale 1ns/1ps
module lnmi_src (
  input  wire logic core_clk,
  input  wire logic nrst,
  lnmi_src_if.latch p
);
  import lnmi_pkg::*;

  lnmi_src_st_t st_r;
  lnmi_src_st_t st_nxt;

  // a disable bit of 1 holds the status clear; an event in the cycle the
  // disable is written is still caught, since the old enable is used
  always_comb begin
    st_nxt         = st_r;
    st_nxt.serr_st = p.serr_dis ? 1'h0 : (st_r.serr_st | p.serr_evt); // RULE4 RULE17
    st_nxt.chk_st  = p.chk_dis ? 1'h0 : (st_r.chk_st | p.chk_lvl);    // RULE3 RULE17
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{serr_st: 1'h0, chk_st: 1'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign p.serr_st = st_r.serr_st;
  assign p.chk_st  = st_r.chk_st;
endmodule // lnmi_src

// file: logic/lnmi_top.sv
// legacy nmi status/control, nmi mask / clock address, and power
// management command and status ports
// assumes i/o cycles decoded to a one-cycle request on core_clk; pins
// serr_n and channel_check_n are asynchronous; refresh_done, counter2_out
// and the smi enable/control bytes come from logic on core_clk
//
// Summary of operation
// RULE1: refresh toggle bit 4 flips per refresh, read-only
// RULE2: software writes bit 4 as zero
// RULE3: bit 3 one clears/disables channel check; zero enables
// RULE4: bit 2 one clears/disables system error; zero enables
// RULE5: bit 1 gates counter 2 onto speaker
// RULE6: bit 0 gates counter 2 counting
// RULE7: mask port bit 7 masks nmi globally
// RULE8: mask bit resets to one
// RULE9: mask port write-only, every access forwarded
// RULE10: mask port low seven bits are clock address
// RULE11: power management ports use byte cycles only
// RULE12: command port stores byte, reads back, resets zero
// RULE13: command write raises smi when both enables set
// RULE14: command read asserts stop clock, never smi
// RULE15: status port stores byte, reads back, resets zero
// RULE16: power management bytes steer nothing else
// RULE17: status bits 7 and 6 latch sources, read-only
// RULE18: status bit 5 reads live counter 2 output
// RULE19: mask set then cleared re-edges pending nmi
// RULE20: nmi high when enabled source set and unmasked
`timescale 1ns/1ps
`include "lnmi_regs.svh"
module lnmi_top (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             io_req,
  input  wire logic             io_wr,
  input  wire logic [15:0]      io_addr,
  input  wire lnmi_pkg::lnmi_byte_t io_wdata,
  output lnmi_pkg::lnmi_byte_t  io_rdata,
  output logic                  io_claim,
  output logic                  isa_fwd,
  output logic                  isa_fwd_wr,
  output lnmi_pkg::lnmi_byte_t  isa_fwd_data,
  input  wire logic             refresh_done,
  input  wire logic             counter2_out,
  input  wire logic             serr_n,
  input  wire logic             channel_check_n,
  input  wire lnmi_pkg::lnmi_byte_t smi_enable_reg,
  input  wire lnmi_pkg::lnmi_byte_t smi_control_reg,
  output logic                  nmi,
  output logic                  speaker_out,
  output logic                  counter2_gate,
  output logic [6:0]            rtc_addr,
  output logic                  smi_req,
  output logic                  stop_clock_n
);
  import lnmi_pkg::*;

  // ----------------------------------------------------------------
  // reset image of the state
  // ----------------------------------------------------------------
  localparam lnmi_top_st_t ST_RST = '{
    ctrl:     `LNMI_CTRL_RST,
    refr:     1'h0,
    mask:     `LNMI_MASK_RST,
    rtc:      `LNMI_RTC_RST,
    pm_cmd:   `LNMI_PM_RST,
    pm_stat:  `LNMI_PM_RST,
    rdata:    8'h00,
    claim:    1'h0,
    fwd:      1'h0,
    fwd_wr:   1'h0,
    fwd_data: 8'h00,
    nmi:      1'h0,
    spk:      1'h0,
    gate:     1'h0,
    smi:      1'h0,
    stp_n:    1'h1
  };

  lnmi_top_st_t st_r;
  lnmi_top_st_t st_nxt;

  // ----------------------------------------------------------------
  // pin synchronisers and source latches
  // ----------------------------------------------------------------
  logic [1:0] pin_low;
  logic [1:0] pin_fall;

  lnmi_sync u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pin_n    ({channel_check_n, serr_n}),
    .low_lvl  (pin_low),
    .fall     (pin_fall)
  );

  lnmi_src_if sif ();

  assign sif.serr_evt = pin_fall[0];
  assign sif.chk_lvl  = pin_low[1];
  assign sif.serr_dis = st_r.ctrl[`LNMI_B_SERR_DIS];
  assign sif.chk_dis  = st_r.ctrl[`LNMI_B_CHK_DIS];

  lnmi_src u_src (
    .core_clk (core_clk),
    .nrst     (nrst),
    .p        (sif.latch)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic hit_nsc;
  logic hit_mask;
  logic hit_cmd;
  logic hit_stat;
  logic wr_any;
  logic rd_any;
  logic pend;
  lnmi_byte_t nsc_view;

  // power management ports are byte wide only; the decode has no cycle width input and takes any cycle at their address
  assign hit_nsc  = io_req && (io_addr == `LNMI_NSC_ADDR);
  assign hit_mask = io_req && (io_addr == `LNMI_MASK_ADDR);
  assign hit_cmd  = io_req && (io_addr == `LNMI_PMCMD_ADDR);  // RULE11
  assign hit_stat = io_req && (io_addr == `LNMI_PMSTAT_ADDR); // RULE11
  assign wr_any   = io_req && io_wr;
  assign rd_any   = io_req && !io_wr;
  assign pend     = sif.serr_st | sif.chk_st;

  // status view: latched sources, live counter 2, toggle, control bits
  always_comb begin
    nsc_view                   = {4'h0, st_r.ctrl};
    nsc_view[`LNMI_B_SERR_ST]  = sif.serr_st;    // RULE17
    nsc_view[`LNMI_B_CHK_ST]   = sif.chk_st;     // RULE17
    nsc_view[`LNMI_B_CNT2]     = counter2_out;   // RULE18
    nsc_view[`LNMI_B_REFR]     = st_r.refr;      // RULE1
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.rdata    = 8'h00;
    st_nxt.claim    = 1'h0;
    st_nxt.fwd      = 1'h0;
    st_nxt.fwd_wr   = 1'h0;
    st_nxt.smi      = 1'h0;

    // toggle on every finished refresh
    if (refresh_done) begin
      st_nxt.refr = ~st_r.refr; // RULE1
    end

    // status/control: only the low four bits are writable
    if (hit_nsc) begin
      st_nxt.claim = 1'h1;
      if (io_wr) begin
        st_nxt.ctrl = io_wdata[3:0]; // RULE2 RULE3 RULE4 RULE5 RULE6
      end else begin
        st_nxt.rdata = nsc_view;
      end
    end

    // mask / clock address: write-only, always passed on
    if (hit_mask) begin
      st_nxt.fwd      = 1'h1;                        // RULE9
      st_nxt.fwd_wr   = io_wr;
      st_nxt.fwd_data = io_wr ? io_wdata : 8'h00;
      if (io_wr) begin
        st_nxt.claim = 1'h1;
        st_nxt.mask  = io_wdata[`LNMI_B_MASK];       // RULE7
        st_nxt.rtc   = io_wdata[6:0];                // RULE10
      end
    end

    // command port: stored byte plus access side effects
    if (hit_cmd) begin
      st_nxt.claim = 1'h1;
      if (io_wr) begin
        st_nxt.pm_cmd = io_wdata; // RULE12 RULE16
        st_nxt.smi    = smi_enable_reg[`LNMI_B_SMI_ENABLE_REG_PM] &
                        smi_control_reg[`LNMI_B_CTL_SMI]; // RULE13
      end else begin
        st_nxt.rdata = st_r.pm_cmd; // RULE12
      end
    end

    // status port: plain storage
    if (hit_stat) begin
      st_nxt.claim = 1'h1;
      if (io_wr) begin
        st_nxt.pm_stat = io_wdata; // RULE15 RULE16
      end else begin
        st_nxt.rdata = st_r.pm_stat; // RULE15
      end
    end

    // stop clock: released when its enable drops, a read sets it again
    if (!smi_control_reg[`LNMI_B_CTL_STP]) begin
      st_nxt.stp_n = 1'h1;
    end
    if (hit_cmd && !io_wr && smi_control_reg[`LNMI_B_CTL_STP]) begin
      st_nxt.stp_n = 1'h0; // RULE14
    end

    // outputs to the speaker, timer gate and processor
    st_nxt.spk  = st_r.ctrl[`LNMI_B_SPK_EN] & counter2_out; // RULE5
    st_nxt.gate = st_r.ctrl[`LNMI_B_GATE];                  // RULE6
    st_nxt.nmi  = pend & ~st_r.mask;                        // RULE20 RULE19
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_RST; // RULE8
    end else begin
      st_r <= st_nxt;
    end
  end

  assign io_rdata      = st_r.rdata;
  assign io_claim      = st_r.claim;
  assign isa_fwd       = st_r.fwd;
  assign isa_fwd_wr    = st_r.fwd_wr;
  assign isa_fwd_data  = st_r.fwd_data;
  assign nmi           = st_r.nmi;
  assign speaker_out   = st_r.spk;
  assign counter2_gate = st_r.gate;
  assign rtc_addr      = st_r.rtc;
  assign smi_req       = st_r.smi;
  assign stop_clock_n  = st_r.stp_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_nsc_wr(int b);
    hit_nsc && io_wr && io_wdata[b];
  endsequence

  sequence s_cmd_wr;
    hit_cmd && io_wr;
  endsequence

  sequence s_cmd_rd;
    hit_cmd && !io_wr;
  endsequence

  sequence s_mask_set;
    $rose(st_r.mask);
  endsequence

  sequence s_mask_clr;
    $fell(st_r.mask) && pend;
  endsequence

  a_refresh_toggle: assert property ( // RULE1
    refresh_done |=> (st_r.refr != $past(st_r.refr)))
    else $error("refresh toggle did not flip");

  a_chk_clear: assert property ( // RULE3
    s_nsc_wr(3) |=> ##1 !sif.chk_st)
    else $error("channel check status not cleared");

  a_serr_clear: assert property ( // RULE4
    s_nsc_wr(2) |=> ##1 !sif.serr_st)
    else $error("system error status not cleared");

  a_speaker_gated: assert property ( // RULE5
    (!st_r.ctrl[`LNMI_B_SPK_EN]) [*2] |-> !speaker_out)
    else $error("speaker driven while disabled");

  // the gate pin lags the control bit by one register stage
  a_gate_write: assert property ( // RULE6
    (hit_nsc && io_wr) |=> ##1 (counter2_gate == $past(io_wdata[0], 2)))
    else $error("counter gate does not follow write");

  a_mask_blocks: assert property ( // RULE7
    st_r.mask |=> !nmi)
    else $error("nmi raised while masked");

  a_mask_forward: assert property ( // RULE9
    hit_mask |=> isa_fwd && (isa_fwd_wr == $past(io_wr)))
    else $error("mask port access not forwarded");

  a_rtc_no_mask: assert property ( // RULE10
    (hit_mask && io_wr) |=> (st_r.mask == $past(io_wdata[7])) &&
      (rtc_addr == $past(io_wdata[6:0])))
    else $error("mask port fields misplaced");

  a_cmd_readback: assert property ( // RULE12
    s_cmd_wr ##1 s_cmd_rd |=> (io_rdata == $past(io_wdata, 2)))
    else $error("command byte not read back");

  a_smi_cause: assert property ( // RULE13
    smi_req |-> $past(hit_cmd && io_wr && smi_enable_reg[7] && smi_control_reg[0]))
    else $error("smi without enabled command write");

  a_read_no_smi: assert property ( // RULE14
    s_cmd_rd |=> !smi_req)
    else $error("command read raised smi");

  a_stop_clock: assert property ( // RULE14
    (s_cmd_rd and smi_control_reg[1]) |=> !stop_clock_n)
    else $error("stop clock not asserted on read");

  a_stat_readback: assert property ( // RULE15
    (hit_stat && io_wr) ##1 (hit_stat && !io_wr) |=> (io_rdata == $past(io_wdata, 2)))
    else $error("status byte not read back");

  a_nmi_drop: assert property ( // RULE19
    s_mask_set |=> !nmi)
    else $error("nmi not dropped by mask");

  a_nmi_reedge: assert property ( // RULE19
    s_mask_clr |=> nmi)
    else $error("nmi not re-raised after unmask");

  a_nmi_source: assert property ( // RULE20
    nmi |-> $past(pend && !st_r.mask))
    else $error("nmi without unmasked source");

  // a write to the status/control port never moves the toggle
  a_refr_readonly: assert property ( // RULE1
    (hit_nsc && io_wr) |=> (st_r.refr == $past(st_r.refr ^ refresh_done)))
    else $error("refresh toggle changed by write");

  a_speaker_follow: assert property ( // RULE5
    st_r.ctrl[`LNMI_B_SPK_EN] |=> (speaker_out == $past(counter2_out)))
    else $error("speaker does not follow counter 2");

  a_cnt2_status: assert property ( // RULE18
    (hit_nsc && !io_wr) |=> (io_rdata[`LNMI_B_CNT2] == $past(counter2_out)))
    else $error("counter 2 status bit stale");

  a_stop_release: assert property ( // RULE14
    !smi_control_reg[`LNMI_B_CTL_STP] |=> stop_clock_n)
    else $error("stop clock held without enable");
endmodule // lnmi_top

// file: verif/lnmi_host.sv
// host model issuing single byte i/o cycles to the port block
// assumes the answer stands in the cycle after the taking edge
`timescale 1ns/1ps
module lnmi_host (
  input  wire logic                 core_clk,
  input  wire lnmi_pkg::lnmi_byte_t io_rdata,
  input  wire logic                 io_claim,
  output logic                      io_req,
  output logic                      io_wr,
  output logic [15:0]               io_addr,
  output lnmi_pkg::lnmi_byte_t      io_wdata
);
  import lnmi_pkg::*;
  initial begin
    io_req   = 1'b0;
    io_wr    = 1'b0;
    io_addr  = 16'hFFFF;
    io_wdata = 8'hFF;
  end
  // -------------------------------------------
  // one byte cycle
  // -------------------------------------------
  task automatic cyc(input logic wr, input logic [15:0] a, input lnmi_byte_t d,
                     output lnmi_byte_t rd, output logic cl);
    @(posedge core_clk);
    io_req   <= 1'b1;
    io_wr    <= wr;
    io_addr  <= a;
    io_wdata <= (a == 16'h0061) ? (d & 8'h0F) : d;
    @(posedge core_clk);
    io_req   <= 1'b0;
    // released lines show the inverse, not the last value
    io_addr  <= ~a;
    io_wdata <= ~d;
    #1;
    rd = io_rdata;
    cl = io_claim;
  endtask
  // -------------------------------------------
  // write then read back, back to back
  // -------------------------------------------
  task automatic wr_rd(input logic [15:0] a, input lnmi_byte_t d, output lnmi_byte_t rd);
    @(posedge core_clk);
    io_req   <= 1'b1;
    io_wr    <= 1'b1;
    io_addr  <= a;
    io_wdata <= d;
    @(posedge core_clk);
    io_wr    <= 1'b0;
    io_wdata <= ~d;
    @(posedge core_clk);
    io_req   <= 1'b0;
    io_addr  <= ~a;
    #1;
    rd = io_rdata;
  endtask
endmodule // lnmi_host

// file: verif/tb_legacy_nmi_apm_control_ports.sv
// self-checking bench for the legacy nmi and power management ports
// assumes lnmi_top and the host model lnmi_host
`timescale 1ns/1ps
module tb_legacy_nmi_apm_control_ports;
  import lnmi_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [15:0] a;
    lnmi_byte_t  d;
    lnmi_byte_t  r;
    logic        c;
  } lnmi_row_t;
  localparam int NROW = 12;
  localparam lnmi_row_t ROWS [NROW] = '{
    '{1'b1, 16'h00B2, 8'h5A, 8'h00, 1'b1},
    '{1'b0, 16'h00B2, 8'h00, 8'h5A, 1'b1},
    '{1'b1, 16'h00B3, 8'hC3, 8'h00, 1'b1},
    '{1'b0, 16'h00B3, 8'h00, 8'hC3, 1'b1},
    '{1'b0, 16'h00B2, 8'h00, 8'h5A, 1'b1},
    '{1'b1, 16'h0061, 8'h0F, 8'h00, 1'b1},
    '{1'b0, 16'h0061, 8'h00, 8'h0F, 1'b1},
    '{1'b1, 16'h0061, 8'h00, 8'h00, 1'b1},
    '{1'b1, 16'h0070, 8'hA5, 8'h00, 1'b1},
    '{1'b0, 16'h0070, 8'h00, 8'h00, 1'b0},
    '{1'b1, 16'h0123, 8'h77, 8'h00, 1'b0},
    '{1'b0, 16'h0071, 8'h00, 8'h00, 1'b0}
  };
  logic        core_clk, nrst, refresh_done, counter2_out, serr_n, channel_check_n;
  logic        io_req, io_wr, io_claim, isa_fwd, isa_fwd_wr, nmi, speaker_out;
  logic        counter2_gate, smi_req, stop_clock_n, cl, tog, fwd_w;
  logic [15:0] io_addr;
  logic [6:0]  rtc_addr;
  lnmi_byte_t  io_wdata, io_rdata, isa_fwd_data, smi_enable_reg, smi_control_reg, rd, fwd_d;
  logic [7:0]  fwd_cnt, smi_cnt;
  int          failures, check_count, cyc_cnt;

  lnmi_top lnmi_top_inst (.core_clk(core_clk), .nrst(nrst), .io_req(io_req), .io_wr(io_wr),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_claim(io_claim),
    .isa_fwd(isa_fwd), .isa_fwd_wr(isa_fwd_wr), .isa_fwd_data(isa_fwd_data),
    .refresh_done(refresh_done), .counter2_out(counter2_out), .serr_n(serr_n),
    .channel_check_n(channel_check_n), .smi_enable_reg(smi_enable_reg),
    .smi_control_reg(smi_control_reg), .nmi(nmi), .speaker_out(speaker_out),
    .counter2_gate(counter2_gate), .rtc_addr(rtc_addr), .smi_req(smi_req),
    .stop_clock_n(stop_clock_n));
  lnmi_host lnmi_host_inst (.core_clk(core_clk), .io_rdata(io_rdata), .io_claim(io_claim),
    .io_req(io_req), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata));

  // -------------------------------------------
  // clock, monitors, timeout
  // -------------------------------------------
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (isa_fwd === 1'b1) begin
      fwd_cnt++;
      fwd_w = isa_fwd_wr;
      if (isa_fwd_wr === 1'b1) fwd_d = isa_fwd_data;
    end
    if (smi_req === 1'b1) smi_cnt++;
    if (cyc_cnt == 3000) begin
      failures++;
      final_report;
    end
  end

  // -------------------------------------------
  // helpers
  // -------------------------------------------
  task automatic chk(input string n, input lnmi_byte_t s, input lnmi_byte_t e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wrp(input logic [15:0] a, input lnmi_byte_t d);
    lnmi_host_inst.cyc(1'b1, a, d, rd, cl);
  endtask
  task automatic rdchk(input logic [15:0] a, input lnmi_byte_t e);
    lnmi_host_inst.cyc(1'b0, a, 8'h00, rd, cl);
    chk("rdata", rd, e);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // -------------------------------------------
  // main sequence
  // -------------------------------------------
  initial begin
    nrst = 1'b0;
    refresh_done = 1'b0;
    counter2_out = 1'b0;
    serr_n = 1'b1;
    channel_check_n = 1'b1;
    smi_enable_reg = 8'h00;
    smi_control_reg = 8'h00;
    fwd_cnt = 8'h00;
    smi_cnt = 8'h00;
    fwd_w = 1'b1;
    fwd_d = 8'h00;
    tog = 1'b0;
    failures = 0;
    check_count = 0;
    cyc_cnt = 0;
    wt(20);
    nrst <= 1'b1;
    for (int i = 0; i < NROW; i++) begin
      lnmi_host_inst.cyc(ROWS[i].wr, ROWS[i].a, ROWS[i].d, rd, cl);
      chk("rdata", rd, ROWS[i].r);
      chk("claim", cl, ROWS[i].c);
    end
    wt(1);
    chk("fwd_cnt", fwd_cnt, 8'h02);
    chk("fwd_wr", fwd_w, 1'b0);
    chk("rtc", {1'b0, rtc_addr}, 8'h25);
    chk("smi", smi_cnt, 8'h00);
    chk("fwd_data", fwd_d, 8'hA5);
    lnmi_host_inst.wr_rd(16'h00B2, 8'h96, rd);
    chk("wr_rd", rd, 8'h96);
    lnmi_host_inst.wr_rd(16'h00B3, 8'h69, rd);
    chk("wr_rd", rd, 8'h69);
    // second reset in mid-run
    nrst <= 1'b0;
    wt(3);
    nrst <= 1'b1;
    rdchk(16'h00B2, 8'h00);
    rdchk(16'h00B3, 8'h00);
    rdchk(16'h0061, 8'h00);
    repeat (2) begin
      tog = ~tog;
      refresh_done <= 1'b1;
      wt(1);
      refresh_done <= 1'b0;
      rdchk(16'h0061, {3'h0, tog, 4'h0});
    end
    wrp(16'h0061, 8'h03);
    counter2_out <= 1'b1;
    wt(3);
    chk("spk", speaker_out, 1'b1);
    chk("gate", counter2_gate, 1'b1);
    rdchk(16'h0061, 8'h23);
    counter2_out <= 1'b0;
    wt(3);
    chk("spk", speaker_out, 1'b0);
    rdchk(16'h0061, 8'h03);
    wrp(16'h0061, 8'h00);
    counter2_out <= 1'b1;
    wt(3);
    chk("spk", speaker_out, 1'b0);
    chk("gate", counter2_gate, 1'b0);
    counter2_out <= 1'b0;
    smi_enable_reg <= 8'h80;
    smi_control_reg <= 8'h01;
    wrp(16'h00B2, 8'h11);
    wt(1);
    chk("smi", smi_cnt, 8'h01);
    smi_control_reg <= 8'h00;
    wrp(16'h00B2, 8'h22);
    smi_enable_reg <= 8'h00;
    smi_control_reg <= 8'h01;
    wrp(16'h00B2, 8'h33);
    smi_enable_reg <= 8'h80;
    smi_control_reg <= 8'h03;
    rdchk(16'h00B2, 8'h33);
    chk("stop", stop_clock_n, 1'b0);
    smi_control_reg <= 8'h00;
    wt(2);
    chk("smi", smi_cnt, 8'h01);
    chk("stop", stop_clock_n, 1'b1);
    // nmi sources, mask still at its reset value
    channel_check_n <= 1'b0;
    wt(8);
    chk("nmi", nmi, 1'b0);
    rdchk(16'h0061, 8'h40);
    wrp(16'h0070, 8'h25);
    wt(2);
    chk("nmi", nmi, 1'b1);
    wrp(16'h0070, 8'h80);
    wt(2);
    chk("nmi", nmi, 1'b0);
    wrp(16'h0070, 8'h25);
    wt(2);
    chk("nmi", nmi, 1'b1);
    wrp(16'h0061, 8'h08);
    wt(2);
    chk("nmi", nmi, 1'b0);
    rdchk(16'h0061, 8'h08);
    channel_check_n <= 1'b1;
    wt(4);
    wrp(16'h0061, 8'h00);
    serr_n <= 1'b0;
    wt(2);
    serr_n <= 1'b1;
    wt(6);
    chk("nmi", nmi, 1'b1);
    rdchk(16'h0061, 8'h80);
    wrp(16'h0061, 8'h04);
    wt(2);
    chk("nmi", nmi, 1'b0);
    serr_n <= 1'b0;
    wt(2);
    serr_n <= 1'b1;
    wt(6);
    rdchk(16'h0061, 8'h04);
    final_report;
  end
endmodule // tb_legacy_nmi_apm_control_ports
